/* File: hdl/awpc_pkg.sv */
// Operation
// - Narrow mode puts bank bits above A23
// - Wide mode ignores bank bits entirely
// - Bank bit7 width, bits1:0 bank
// - Bank register defaults to all zero
// - Bank bits kept volatile and non-volatile
// - Opcodes 2Bh read, 2Fh program config
// - Config bit1 persistent lock, bit2 password
// - Lock field 11 none, 10 persistent, 01 password
// - Programming lock field 00 aborts with error
// - After a lock, any other lock field raises error
// - Ships persistent mode, sectors unprotected
// - Config program busy one page time
// - Config bit15 places parameter sectors
// - Parameter region is thirty-two 4KB sectors
// - Parameter location ships one, one-way only
// - Location programmable after lock unless frozen
// - Large block variant has no parameter sectors
// - Protect select independent of parameter location
// - Bank opcodes 16h/C8h 17h/C5h 18h B7h 29h
// - Error flags sticky until clear or reset
// - Freeze blocks parameter location changes
package awpc_pkg;
  typedef enum logic [1:0] {AWPC_IDLE = 2'b01, AWPC_BUSY = 2'b10} awpc_state_t;
  typedef struct packed {
    logic       wide;
    logic [1:0] bank;
  } awpc_bank_t;
  localparam logic [7:0] OP_RD_BANK_A  = 8'h16;
  localparam logic [7:0] OP_RD_BANK_B  = 8'hc8;
  localparam logic [7:0] OP_WR_BANK_VA = 8'h17;
  localparam logic [7:0] OP_WR_BANK_VB = 8'hc5;
  localparam logic [7:0] OP_WR_BANK_NV = 8'h18;
  localparam logic [7:0] OP_RD_BANK_NV = 8'h19;
  localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
  localparam logic [7:0] OP_EXIT_WIDE  = 8'h29;
  localparam logic [7:0] OP_RD_PROT    = 8'h2b;
  localparam logic [7:0] OP_PG_PROT    = 8'h2f;
  localparam logic [7:0] OP_CLR_ERR    = 8'h82;
  localparam int BA_WIDE_BIT  = 7;
  localparam int BA_BANK_HI   = 1;
  localparam int BA_BANK_LO   = 0;
  localparam int PC_PARAM_BIT = 15;
  localparam int PC_PWD_BIT   = 2;
  localparam int PC_PST_BIT   = 1;
  localparam logic [1:0] LOCK_NONE = 2'b11;
  localparam logic [1:0] LOCK_PST  = 2'b10;
  localparam logic [1:0] LOCK_PWD  = 2'b01;
  localparam logic [1:0] LOCK_BOTH = 2'b00;
  localparam logic [15:0] PC_DEFAULT   = 16'hffff;
  localparam awpc_bank_t  BANK_DEFAULT = 3'h0;
  localparam logic [4:0] LEN_OP   = 5'h08;
  localparam logic [4:0] LEN_BYTE = 5'h10;
  localparam logic [4:0] LEN_WORD = 5'h18;
  localparam logic [4:0] LEN_MAX  = 5'h1f;
  localparam logic [25:0] PARAM_SIZE = 26'h0020000;
  localparam logic [25:0] PARAM_TOP  = 26'h3fe0000;
  localparam logic [25:0] PARAM_BOT  = 26'h0000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_US  = 200;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
endpackage : awpc_pkg

/* File: hdl/awpc_top.sv */
`timescale 1ns/1ps
module awpc_top #(
  parameter int PROG_CYCLES = awpc_pkg::PROG_CYCLES_DFLT,
  parameter bit BLOCK_256K  = 1'b0
) (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        hw_reset_n_in,
  input  wire logic        soft_reset_in,
  input  wire logic        freeze_in,
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  output wire logic        miso_out,
  output wire logic        miso_oe_n_out,
  input  wire logic        cmd_start_in,
  input  wire logic        addr_valid_in,
  input  wire logic [31:0] addr_in,
  output wire logic [25:0] eff_addr_out,
  output wire logic        param_hit_out,
  output wire logic        wide_address_select_out,
  output wire logic        write_in_progress_out,
  output wire logic        program_error_flag_out,
  output wire logic        protection_error_flag_out,
  output wire logic        password_mode_out,
  output wire logic        persistent_locked_out,
  output wire logic        param_sector_location_out
);
  import awpc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // bit positions
  function automatic awpc_bank_t to_bank(input logic [7:0] b);
    to_bank = {b[BA_WIDE_BIT], b[BA_BANK_HI], b[BA_BANK_LO]};
  endfunction : to_bank

  function automatic logic [7:0] from_bank(input awpc_bank_t v);
    from_bank = {v.wide, 5'h00, v.bank};
  endfunction : from_bank

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_RD_BANK_A) || (op == OP_RD_BANK_B) ||
              (op == OP_RD_BANK_NV) || (op == OP_RD_PROT);
  endfunction : is_read

  // ----------------------------------------
  // Serial link domain
  // ----------------------------------------
  logic [4:0]  bit_cnt_r;
  logic [4:0]  len_r;
  logic [23:0] shift_r;
  logic [7:0]  op_r;
  logic        miso_r;
  logic        oe_n_r;
  logic [7:0]  bank_rd_r;
  logic [7:0]  bank_nv_rd_r;
  logic [15:0] prot_rd_r;

  wire [4:0]  cnt_inc = (bit_cnt_r == LEN_MAX) ? bit_cnt_r : bit_cnt_r + 5'h01;
  wire        rd_prot = (op_r == OP_RD_PROT);
  wire        rd_nv   = (op_r == OP_RD_BANK_NV);
  wire [15:0] rd_word = rd_prot ? prot_rd_r :
                        rd_nv ? {bank_nv_rd_r, bank_nv_rd_r} : {bank_rd_r, bank_rd_r};
  // Low byte first, each byte MSB first
  wire [3:0]  rd_idx  = {~bit_cnt_r[3], 3'h7 - bit_cnt_r[2:0]};
  wire        rd_slot = (bit_cnt_r >= LEN_OP) && is_read(op_r);

  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt_r <= 5'h00;
    end else begin
      bit_cnt_r <= cnt_inc;
    end
  end

  // Capture stays put after the frame for the core to pick up
  always_ff @(posedge sck_in) begin
    shift_r <= {shift_r[22:0], mosi_in};
    len_r   <= cnt_inc;
    if (bit_cnt_r == LEN_OP - 5'h01) begin
      op_r <= {shift_r[6:0], mosi_in};
    end
  end

  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      miso_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      miso_r <= rd_slot ? rd_word[rd_idx] : 1'b0;
      oe_n_r <= ~rd_slot;
    end
  end

  assign miso_out      = miso_r;
  assign miso_oe_n_out = oe_n_r;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic hrst_s1_r, hrst_s2_r;
  logic frz_s1_r, frz_s2_r;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      hrst_s1_r <= 1'b1;
      hrst_s2_r <= 1'b1;
      frz_s1_r  <= 1'b0;
      frz_s2_r  <= 1'b0;
    end else begin
      cs_s1_r   <= cs_n_in;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      hrst_s1_r <= hw_reset_n_in;
      hrst_s2_r <= hrst_s1_r;
      frz_s1_r  <= freeze_in;
      frz_s2_r  <= frz_s1_r;
    end
  end

  wire frame_end = cs_s2_r & ~cs_s3_r;
  wire warm      = ~hrst_s2_r | soft_reset_in;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  awpc_state_t state_r, state_nxt;
  awpc_bank_t  ba_v_r, ba_v_nxt;
  awpc_bank_t  ba_nv_r, ba_nv_nxt;
  awpc_bank_t  pend_bank_r;
  awpc_bank_t  lat_r;
  logic [1:0]  lock_r, lock_nxt;
  logic        param_r, param_nxt;
  logic        pgm_err_r, prot_err_r;
  logic        pend_nv_r;
  logic [15:0] pend_word_r;
  logic [31:0] busy_cnt_r;
  logic [25:0] eff_addr_r;
  logic        param_hit_r;

  wire        idle     = (state_r == AWPC_IDLE);
  wire        take     = frame_end & idle;
  wire        len_op   = (len_r == LEN_OP);
  wire        len_byte = (len_r == LEN_BYTE);
  wire        do_wrv   = take & len_byte & ((op_r == OP_WR_BANK_VA) | (op_r == OP_WR_BANK_VB));
  wire        do_wrnv  = take & len_byte & (op_r == OP_WR_BANK_NV);
  wire        do_en    = take & len_op & (op_r == OP_ENTER_WIDE);
  wire        do_ex    = take & len_op & (op_r == OP_EXIT_WIDE);
  wire        do_pg    = take & (len_r == LEN_WORD) & (op_r == OP_PG_PROT);
  wire        do_clr   = frame_end & len_op & (op_r == OP_CLR_ERR);
  wire [15:0] pg_word  = {shift_r[7:0], shift_r[15:8]};
  wire [1:0]  pg_lock  = pg_word[PC_PWD_BIT:PC_PST_BIT];
  wire        pg_both  = (pg_lock == LOCK_BOTH);
  wire        pg_relock = (lock_r != LOCK_NONE) && (pg_lock != lock_r);
  wire        pg_fail  = do_pg & (pg_both | pg_relock);
  wire        pg_go    = do_pg & ~pg_fail;
  wire        busy_done = (busy_cnt_r == 32'(PROG_CYCLES - 1));
  wire        commit   = ~idle & busy_done & ~warm;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AWPC_IDLE: begin
        if (pg_go | do_wrnv) begin
          state_nxt = AWPC_BUSY;
        end
      end
      AWPC_BUSY: begin
        if (warm | busy_done) begin
          state_nxt = AWPC_IDLE;
        end
      end
      default: state_nxt = AWPC_IDLE;
    endcase
  end

  always_comb begin
    ba_v_nxt = ba_v_r;
    if (warm) begin
      ba_v_nxt = ba_nv_r;
    end else if (commit & pend_nv_r) begin
      ba_v_nxt = pend_bank_r;
    end else if (do_wrv) begin
      ba_v_nxt = to_bank(shift_r[7:0]);
    end else if (do_en) begin
      ba_v_nxt.wide = 1'b1;
    end else if (do_ex) begin
      ba_v_nxt.wide = 1'b0;
    end
  end

  assign ba_nv_nxt = (commit & pend_nv_r) ? pend_bank_r : ba_nv_r;
  assign lock_nxt  = (commit & ~pend_nv_r) ? (lock_r & pend_word_r[PC_PWD_BIT:PC_PST_BIT]) : lock_r;
  assign param_nxt = (commit & ~pend_nv_r & ~frz_s2_r & ~BLOCK_256K) ?
                     (param_r & pend_word_r[PC_PARAM_BIT]) : param_r;

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  // bank default zero
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_r <= AWPC_IDLE;
      ba_v_r  <= BANK_DEFAULT;
      ba_nv_r <= BANK_DEFAULT;
      lock_r  <= LOCK_NONE;
      param_r <= PC_DEFAULT[PC_PARAM_BIT];
    end else begin
      state_r <= state_nxt;
      ba_v_r  <= ba_v_nxt;
      ba_nv_r <= ba_nv_nxt;
      lock_r  <= lock_nxt;
      param_r <= param_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      busy_cnt_r <= idle ? 32'h0000_0000 : busy_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pend_nv_r   <= 1'b0;
      pend_bank_r <= BANK_DEFAULT;
      pend_word_r <= PC_DEFAULT;
    end else if (take) begin
      pend_nv_r   <= do_wrnv;
      pend_bank_r <= to_bank(shift_r[7:0]);
      pend_word_r <= pg_word;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pgm_err_r  <= 1'b0;
      prot_err_r <= 1'b0;
    end else begin
      pgm_err_r  <= pg_fail | (pgm_err_r & ~(do_clr | warm));
      prot_err_r <= pg_fail | (prot_err_r & ~(do_clr | warm));
    end
  end

  // ----------------------------------------
  // Read images for the link
  // ----------------------------------------
  // reserved bits default
  wire [15:0] prot_img = {param_r | BLOCK_256K, PC_DEFAULT[14:3], lock_r, PC_DEFAULT[0]};

  // Images move only between frames so the link sees stable words
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      bank_rd_r    <= 8'h00;
      bank_nv_rd_r <= 8'h00;
      prot_rd_r    <= PC_DEFAULT;
    end else if (cs_s2_r) begin
      bank_rd_r    <= from_bank(ba_v_r);
      bank_nv_rd_r <= from_bank(ba_nv_r);
      prot_rd_r    <= prot_img;
    end
  end

  // ----------------------------------------
  // Address path
  // ----------------------------------------
  // location selects base
  wire [25:0] param_base = param_r ? PARAM_BOT : PARAM_TOP;
  wire [25:0] eff_nxt = lat_r.wide ? addr_in[25:0] : {lat_r.bank, addr_in[23:0]};
  // protect select not consulted
  // Region end carries one extra bit, the top region ends at the array size
  wire [26:0] param_end = {1'b0, param_base} + {1'b0, PARAM_SIZE};
  wire        hit_nxt = ~BLOCK_256K && (eff_nxt >= param_base) &&
                        ({1'b0, eff_nxt} < param_end);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lat_r <= BANK_DEFAULT;
    end else if (cmd_start_in) begin
      lat_r <= ba_v_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      eff_addr_r  <= 26'h0000000;
      param_hit_r <= 1'b0;
    end else if (addr_valid_in) begin
      eff_addr_r  <= eff_nxt;
      param_hit_r <= hit_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign eff_addr_out              = eff_addr_r;
  assign param_hit_out             = param_hit_r;
  assign wide_address_select_out   = ba_v_r.wide;
  assign write_in_progress_out     = ~idle;
  assign program_error_flag_out    = pgm_err_r;
  assign protection_error_flag_out = prot_err_r;
  assign password_mode_out         = (lock_r == LOCK_PWD);
  assign persistent_locked_out     = (lock_r == LOCK_PST);
  assign param_sector_location_out = param_r | BLOCK_256K;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence pg_start_s;
    pg_go ##1 write_in_progress_out;
  endsequence

  sequence pg_reject_s;
    pg_fail ##1 (pgm_err_r && prot_err_r && !write_in_progress_out);
  endsequence

  bank_narrow_a: assert property (addr_valid_in && !lat_r.wide |=>
    eff_addr_out == {$past(lat_r.bank), $past(addr_in[23:0])})
    else $error("bank bits not used in narrow mode");

  bank_wide_a: assert property (addr_valid_in && lat_r.wide |=>
    eff_addr_out == $past(addr_in[25:0]))
    else $error("wide address not passed whole");

  bank_default_a: assert property (@(posedge clock_in) disable iff (1'b0) reset_in |=>
    ba_v_r == BANK_DEFAULT && ba_nv_r == BANK_DEFAULT && lock_r == LOCK_NONE)
    else $error("defaults wrong after reset");

  lock_zero_a: assert property (do_pg && pg_both |->
    pg_reject_s)
    else $error("both-lock program not refused");

  lock_again_a: assert property (do_pg && pg_relock |=>
    pgm_err_r && $stable(lock_r))
    else $error("relock not refused");

  prog_busy_a: assert property (pg_start_s |->
    write_in_progress_out [*8])
    else $error("busy ended too soon");

  busy_bound_a: assert property (write_in_progress_out |->
    busy_cnt_r < 32'(PROG_CYCLES))
    else $error("busy overran program time");

  param_otp_a: assert property (!param_r |=> !param_r)
    else $error("location returned to one");

  freeze_hold_a: assert property (frz_s2_r |=> $stable(param_r))
    else $error("location changed while frozen");

  err_sticky_a: assert property (pgm_err_r && !do_clr && !warm |=>
    pgm_err_r)
    else $error("error flag dropped early");

  width_latch_a: assert property (!cmd_start_in |=> $stable(lat_r))
    else $error("latched width moved mid command");

  read_drive_a: assert property (@(negedge sck_in) disable iff (cs_n_in)
    !oe_n_r |-> is_read(op_r))
    else $error("output driven outside a read");
endmodule : awpc_top

/* File: bench/awpc_spi_host.sv */
`timescale 1ns/1ps
module awpc_spi_host (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in,
  input  wire logic miso_oe_n_in
);
  logic [31:0] rx;

  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    rx       = 32'h0;
  end

  // ----------------------------------------
  // Mode 0 frame, clock still between frames
  // ----------------------------------------
  task automatic frame(input logic [23:0] tx, input int nb, input int nr);
    cs_n_out = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      mosi_out = tx[i];
      #7.5 sck_out = 1'b1;
      #7.5 sck_out = 1'b0;
    end
    // Released data line toggles, undriven read bits show as unknown
    for (int i = 0; i < nr; i++) begin
      mosi_out = ~mosi_out;
      #7.5 sck_out = 1'b1;
      rx = {rx[30:0], miso_oe_n_in ? 1'bx : miso_in};
      #7.5 sck_out = 1'b0;
    end
    #7.5 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask : frame
endmodule : awpc_spi_host

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import awpc_pkg::*;
  localparam int PROG = 20;
  logic        clock_in, reset_in, hw_reset_n, soft_reset, freeze, cmd_start, addr_valid;
  logic [31:0] addr;
  wire  logic  sck, cs_n, mosi, miso, miso_oe_n, hit, wide, write_in_progress, perr, proterr, pwd, pst, loc;
  wire  logic [25:0] eff;
  int          n_mismatch, compares, busy;

  awpc_top #(.PROG_CYCLES(PROG)) awpc_top_i (
    .clock_in(clock_in), .reset_in(reset_in), .hw_reset_n_in(hw_reset_n),
    .soft_reset_in(soft_reset), .freeze_in(freeze), .sck_in(sck), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_n_out(miso_oe_n), .cmd_start_in(cmd_start),
    .addr_valid_in(addr_valid), .addr_in(addr), .eff_addr_out(eff), .param_hit_out(hit),
    .wide_address_select_out(wide), .write_in_progress_out(write_in_progress), .program_error_flag_out(perr),
    .protection_error_flag_out(proterr), .password_mode_out(pwd), .persistent_locked_out(pst),
    .param_sector_location_out(loc));

  awpc_spi_host awpc_spi_host_i (
    .sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso), .miso_oe_n_in(miso_oe_n));

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cyc

  // One frame, then a window that counts busy cycles and must end idle
  task automatic spi(input logic [23:0] tx, input int nb, input int nr);
    awpc_spi_host_i.frame(tx, nb, nr);
    cyc(1);
    busy = 0;
    for (int i = 0; i < 60; i++) begin
      cyc(1);
      busy += write_in_progress;
    end
    if (write_in_progress !== 1'b0) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : spi

  task automatic cmd8(input logic [7:0] op);
    spi({16'h0, op}, 8, 0);
  endtask : cmd8

  task automatic wr_bank(input logic [7:0] op, input logic [7:0] d);
    spi({8'h0, op, d}, 16, 0);
  endtask : wr_bank

  task automatic pg_cfg(input logic [15:0] v, input int exp_busy);
    spi({OP_PG_PROT, v[7:0], v[15:8]}, 24, 0);
    chk("busy cycles", exp_busy, busy);
  endtask : pg_cfg

  task automatic rd_bank(input logic [7:0] op, input logic [7:0] exp);
    spi({16'h0, op}, 8, 8);
    chk("bank read", exp, awpc_spi_host_i.rx[7:0]);
  endtask : rd_bank

  task automatic rd_cfg(input logic [15:0] exp);
    spi({16'h0, OP_RD_PROT}, 8, 16);
    chk("config read", {exp[7:0], exp[15:8]}, awpc_spi_host_i.rx[15:0]);
  endtask : rd_cfg

  // Order: wide, program error, protection error, password, persistent, location
  task automatic flags(input logic [5:0] exp);
    chk("flags", exp, {wide, perr, proterr, pwd, pst, loc});
  endtask : flags

  task automatic start;
    cmd_start = 1'b1;
    cyc(1);
    cmd_start = 1'b0;
  endtask : start

  task automatic xlate(input bit st, input logic [31:0] a, input logic [26:0] exp);
    if (st) start();
    addr_valid = 1'b1;
    addr = a;
    cyc(1);
    addr_valid = 1'b0;
    cyc(1);
    chk("address", exp, {hit, eff});
  endtask : xlate

  task automatic por;
    reset_in = 1'b1;
    cyc(8);
    reset_in = 1'b0;
    cyc(4);
  endtask : por

  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset_in, soft_reset, freeze, cmd_start, addr_valid} = 5'h0;
    hw_reset_n = 1'b1;
    addr = 32'h0;
    por();
    flags(6'h01);
    rd_bank(OP_RD_BANK_A, 8'h00);
    rd_cfg(16'hffff);
    wr_bank(OP_WR_BANK_VA, 8'hff);
    rd_bank(OP_RD_BANK_B, 8'h83);
    flags(6'h21);
    wr_bank(OP_WR_BANK_VB, 8'h02);
    chk("busy cycles", 0, busy);
    rd_bank(OP_RD_BANK_A, 8'h02);
    xlate(1, 32'hff123456, {1'b0, 26'h2123456});
    wr_bank(OP_WR_BANK_VA, 8'h00);
    xlate(1, 32'h0001ffff, {1'b1, 26'h001ffff});
    xlate(1, 32'h00020000, {1'b0, 26'h0020000});
    wr_bank(OP_WR_BANK_VA, 8'h02);
    start();
    cmd8(OP_ENTER_WIDE);
    xlate(0, 32'h00000010, {1'b0, 26'h2000010});
    xlate(1, 32'h00000010, {1'b1, 26'h0000010});
    cmd8(OP_EXIT_WIDE);
    flags(6'h01);
    wr_bank(OP_WR_BANK_NV, 8'h81);
    chk("busy cycles", PROG, busy);
    rd_bank(OP_RD_BANK_NV, 8'h81);
    for (int k = 0; k < 2; k++) begin
      wr_bank(OP_WR_BANK_VA, 8'h00);
      if (k == 0) hw_reset_n = 1'b0;
      else soft_reset = 1'b1;
      cyc(k == 0 ? 4 : 1);
      {hw_reset_n, soft_reset} = 2'b10;
      cyc(6);
      rd_bank(OP_RD_BANK_A, 8'h81);
    end
    wr_bank(OP_WR_BANK_VA, 8'h00);
    pg_cfg(16'hfff9, 0);
    flags(6'h19);
    rd_cfg(16'hffff);
    wr_bank(OP_WR_BANK_VA, 8'h01);
    rd_bank(OP_RD_BANK_A, 8'h01);
    flags(6'h19);
    cmd8(OP_CLR_ERR);
    flags(6'h01);
    pg_cfg(16'hfffd, PROG);
    flags(6'h03);
    pg_cfg(16'h7ffd, PROG);
    flags(6'h02);
    rd_cfg(16'h7ffd);
    pg_cfg(16'hfffb, 0);
    flags(6'h1a);
    cmd8(OP_CLR_ERR);
    pg_cfg(16'hfffd, PROG);
    flags(6'h02);
    rd_cfg(16'h7ffd);
    cmd8(OP_ENTER_WIDE);
    xlate(1, 32'h03fe0000, {1'b1, 26'h3fe0000});
    xlate(1, 32'h03fdffff, {1'b0, 26'h3fdffff});
    por();
    flags(6'h01);
    freeze = 1'b1;
    cyc(4);
    pg_cfg(16'h7ffb, PROG);
    flags(6'h05);
    rd_cfg(16'hfffb);
    freeze = 1'b0;
    report_and_stop();
  end
endmodule : tb
